// [inc/bps_defs.svh]
/*
 * Named constants of the bypass serial supervisor: codes, limits, times.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define BPS_CLK_NS 5
`define BPS_MS_NS 1000000
`define BPS_TENTH_MS 17'h64

// ****************************************************************
// Protocol and parity codes
// ****************************************************************
`define BPS_PROTO_BACNET 2'h3
`define BPS_PAR_NONE 2'h0
`define BPS_PAR_EVEN 2'h1
`define BPS_PAR_ODD 2'h2

// ****************************************************************
// Loss reaction codes
// ****************************************************************
`define BPS_REACT_IGNORE 3'h0
`define BPS_REACT_ALARM 3'h1
`define BPS_REACT_FAULT 3'h2
`define BPS_REACT_FAULT_OPEN 3'h3
`define BPS_REACT_PRESET 3'h4

// ****************************************************************
// Retention codes and retained word layout
// ****************************************************************
`define BPS_RET_NONE 2'h0
`define BPS_RET_REF 2'h1
`define BPS_RET_RUN 2'h2
`define BPS_RET_BOTH 2'h3
`define BPS_ADDR_FREQ 1'h0
`define BPS_ADDR_CMD 1'h1
`define BPS_CMD_RETAIN_MASK 16'h07ff
`define BPS_CMD_FAULT_RESET 11
`define BPS_CMD_RUN_FWD 0
`define BPS_CMD_RUN_REV 1

// ****************************************************************
// Range limits
// ****************************************************************
`define BPS_SPEED_MAX 10'h258
`define BPS_ID_HIGH_MAX 16'h003f

`endif

// [inc/bps_pkg.sv]
/*
 * Types of the bypass serial supervisor: restore sequence and state record.
 * Assumes the constants header sits on the include path.
 */
package bps_pkg;

    // Restore sequence after power returns.
    typedef enum logic [1:0] {
        ST_RD_FREQ = 2'b00,
        ST_RD_CMD = 2'b01,
        ST_APPLY = 2'b10,
        ST_RUN = 2'b11
    } bps_state_t;

    // Whole state of the supervisor in one record.
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [17:0] div;
        logic [16:0] ms_cnt;
        logic loss;
        logic [24:0] dly_cnt;
        logic dly_run;
        logic tx_go;
        bps_state_t st;
        logic [15:0] freq_ref;
        logic [11:0] cmd;
        logic alarm;
        logic ext_fault;
        logic k3_open;
        logic preset;
        logic [15:0] speed;
        logic [7:0] merged;
        logic [1:0] parity;
        logic [21:0] inst_id;
    } bps_state_rec_t;

endpackage

// [verilog/bps_ret_mem.sv]
/*
 * Retained command store: a tiny memory whose contents survive a reset.
 * Assumes one writer and one reader on the same clock; read data registered.
 */
`timescale 1ns/1ps
`include "bps_defs.svh"

module bps_ret_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Write port.
    input wire logic we,
    input wire logic waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read port.
    input wire logic raddr,
    output logic [WIDTH-1:0] rdata_q
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    // The array has no reset on purpose: it stands for non-volatile cells.
    logic [WIDTH-1:0] mem [DEPTH];

    // Write side.
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read, cleared only by reset.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule // bps_ret_mem

// [verilog/bps_supervisor.sv]
/*
 * Bypass serial supervisor: parity choice, response delay, loss detection
 * and reaction, preset speed, instance identifier, input merge, retention.
 * Assumes the protocol engine on sys_clk gives one-cycle frame and command
 * pulses and a word write port; physical inputs come from pins.
 */
`timescale 1ns/1ps
`include "bps_defs.svh"

// Behaviour
// - Parity codes none, even, odd
// - BACnet active ignores parity selection
// - Loss declared once silence reaches loss time
// - Loss time 0..99.9 s; zero disables
// - Reaction 0 ignores, 1 alarms only
// - Reaction 2 sends external fault
// - Reaction 3 faults and opens contactor
// - Reaction 4 alarms, runs preset speed
// - Preset speed 0..60 Hz, reaction 4
// - Response waits programmed 0..99 ms
// - Instance id: low word, high capped 3Fh
// - Detect enable zero suppresses any reaction
// - Input select zero ignores network inputs
// - Input select one ORs eight inputs
// - Restore commands except fault reset bit
// - Retention code picks reference, commands, both
// - Retention only under BACnet with serial source
// - Retained commands are eleven bypass objects
// - Restored run may start without message
module bps_supervisor #(
    parameter int MS_CYCLES = `BPS_MS_NS / `BPS_CLK_NS
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Configuration.
    input wire logic [1:0] protocol_select,
    input wire logic [1:0] parity_select,
    input wire logic [2:0] loss_reaction_select,
    input wire logic [9:0] loss_time,
    input wire logic [6:0] response_delay,
    input wire logic [15:0] instance_id_low,
    input wire logic [15:0] instance_id_high,
    input wire logic [9:0] cable_loss_speed,
    input wire logic loss_detect_enable,
    input wire logic net_input_select,
    input wire logic [1:0] command_retention_select,
    input wire logic speed_ref_serial,
    input wire logic run_cmd_serial,
    // Protocol engine events and command writes.
    input wire logic frame_ok,
    input wire logic cmd_received,
    input wire logic net_wr,
    input wire logic net_addr,
    input wire logic [15:0] net_wdata,
    // Digital inputs.
    input wire logic [7:0] physical_inputs,
    input wire logic [7:0] net_inputs,
    // Serial link settings and timing.
    output logic [1:0] parity_mode,
    output logic tx_ready,
    output logic [21:0] device_instance,
    // Loss supervision.
    output logic comm_loss,
    output logic comm_loss_alarm,
    output logic network_external_fault,
    output logic bypass_contactor_open,
    output logic preset_active,
    // Commands toward drive and bypass.
    output logic [15:0] speed_ref_out,
    output logic [11:0] cmd_out,
    output logic run_cmd,
    output logic [7:0] merged_inputs,
    output logic ready
);

    // ****************************************************************
    // State and memory wiring
    // ****************************************************************
    bps_pkg::bps_state_rec_t s_q; // Registered state.
    bps_pkg::bps_state_rec_t s_d; // Next state.
    logic [15:0] mem_rdata; // Registered read data of the store.
    logic mem_raddr; // Word being read during restore.
    logic [15:0] mem_wdata; // Word stored, fault reset stripped.
    logic [16:0] loss_limit; // Loss time in milliseconds.
    logic ret_ok; // Retention is allowed in this setup.

    // Restore reads the reference first, then the command word.
    assign mem_raddr = (s_q.st == bps_pkg::ST_RD_CMD) ?
                       `BPS_ADDR_CMD : `BPS_ADDR_FREQ;

    // The fault reset bit never reaches the store.
    assign mem_wdata = (net_addr == `BPS_ADDR_CMD) ?
                       (net_wdata & `BPS_CMD_RETAIN_MASK) : net_wdata;

    // Tenths of a second become milliseconds.
    assign loss_limit = 17'(loss_time) * `BPS_TENTH_MS;

    // Retention needs BACnet and a serial reference or run source.
    assign ret_ok = (protocol_select == `BPS_PROTO_BACNET) &&
                    (speed_ref_serial || run_cmd_serial);

    // Every accepted write also lands in the retained store.
    bps_ret_mem #(
        .WIDTH(16),
        .DEPTH(2)
    ) u_mem (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .we(net_wr && (s_q.st == bps_pkg::ST_RUN)),
        .waddr(net_addr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata)
    );

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // True when the restore code covers the given part.
    function automatic logic ret_has(input logic [1:0] code,
                                     input logic [1:0] part);
        ret_has = (code == `BPS_RET_BOTH) || (code == part);
    endfunction

    // True when the active reaction matches one of two codes.
    function automatic logic react_is(input logic [2:0] code,
                                      input logic [2:0] a,
                                      input logic [2:0] b);
        react_is = (code == a) || (code == b);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // One process computes the whole record; outputs are taken from it.
    always_comb begin
        logic act; // Loss present and supervision enabled.
        logic [2:0] rc; // Reaction code in use.
        s_d = s_q;
        act = 1'b0;
        rc = loss_reaction_select;

        // Pin inputs pass two flops before anything reads them.
        s_d.sync1 = physical_inputs;
        s_d.sync2 = s_q.sync1;

        // Merge network inputs only when selected.
        if (net_input_select) begin
            s_d.merged = s_q.sync2 | net_inputs;
        end else begin
            s_d.merged = s_q.sync2;
        end

        // Parity follows its code, but BACnet frames carry none.
        if (protocol_select == `BPS_PROTO_BACNET) begin
            s_d.parity = `BPS_PAR_NONE;
        end else if (parity_select == `BPS_PAR_EVEN ||
                     parity_select == `BPS_PAR_ODD) begin
            s_d.parity = parity_select;
        end else begin
            s_d.parity = `BPS_PAR_NONE;
        end

        // High word is capped so the identifier stays in range.
        if (instance_id_high > `BPS_ID_HIGH_MAX) begin
            s_d.inst_id = {6'h3f, instance_id_low};
        end else begin
            s_d.inst_id = {instance_id_high[5:0], instance_id_low};
        end

        // Loss timer: a good frame restarts the millisecond phase too,
        // so silence is measured from the frame itself.
        if (frame_ok) begin
            s_d.div = '0;
            s_d.ms_cnt = '0;
            s_d.loss = 1'b0;
        end else if (loss_time == 10'h000) begin
            // Zero loss time switches supervision off.
            s_d.div = '0;
            s_d.ms_cnt = '0;
            s_d.loss = 1'b0;
        end else if (s_q.div == 18'(MS_CYCLES - 1)) begin
            s_d.div = '0;
            if (!s_q.loss) begin
                s_d.ms_cnt = s_q.ms_cnt + 17'h00001;
                // Silence reached the limit.
                if (s_q.ms_cnt + 17'h00001 >= loss_limit) begin
                    s_d.loss = 1'b1;
                end
            end
        end else begin
            s_d.div = s_q.div + 18'h00001;
        end

        // Reactions are gated by the detection enable.
        act = s_q.loss && loss_detect_enable;
        // Codes 1 and 4 alarm; code 0 does nothing.
        s_d.alarm = act && react_is(rc, `BPS_REACT_ALARM, `BPS_REACT_PRESET);
        // Codes 2 and 3 send the external fault.
        s_d.ext_fault = act && react_is(rc, `BPS_REACT_FAULT,
                                        `BPS_REACT_FAULT_OPEN);
        // Code 3 also opens the bypass contactor.
        s_d.k3_open = act && (rc == `BPS_REACT_FAULT_OPEN);
        // Code 4 keeps running at the capped preset speed.
        s_d.preset = act && (rc == `BPS_REACT_PRESET);
        if (s_d.preset) begin
            if (cable_loss_speed > `BPS_SPEED_MAX) begin
                s_d.speed = 16'(`BPS_SPEED_MAX);
            end else begin
                s_d.speed = 16'(cable_loss_speed);
            end
        end else begin
            s_d.speed = s_q.freq_ref;
        end

        // Response delay in whole milliseconds; zero answers two edges after the command.
        s_d.tx_go = 1'b0;
        if (cmd_received) begin
            s_d.dly_cnt = 25'(response_delay) * 25'(MS_CYCLES);
            s_d.dly_run = 1'b1;
        end else if (s_q.dly_run) begin
            if (s_q.dly_cnt == 25'h0000000) begin
                s_d.dly_run = 1'b0;
                s_d.tx_go = 1'b1;
            end else begin
                s_d.dly_cnt = s_q.dly_cnt - 25'h0000001;
            end
        end

        // Restore sequence, then live command writes.
        case (s_q.st)
            bps_pkg::ST_RD_FREQ: begin
                s_d.st = bps_pkg::ST_RD_CMD;
            end
            bps_pkg::ST_RD_CMD: begin
                // Reference word is on the read port now.
                if (ret_ok && ret_has(command_retention_select,
                                      `BPS_RET_REF)) begin
                    s_d.freq_ref = mem_rdata;
                end
                s_d.st = bps_pkg::ST_APPLY;
            end
            bps_pkg::ST_APPLY: begin
                // Eleven command objects, never the fault reset.
                if (ret_ok && ret_has(command_retention_select,
                                      `BPS_RET_RUN)) begin
                    s_d.cmd = mem_rdata[11:0] & 12'h7ff;
                end
                s_d.st = bps_pkg::ST_RUN;
            end
            bps_pkg::ST_RUN: begin
                if (net_wr && net_addr == `BPS_ADDR_FREQ) begin
                    s_d.freq_ref = net_wdata;
                end else if (net_wr) begin
                    s_d.cmd = net_wdata[11:0];
                end
            end
            default: begin
                s_d.st = bps_pkg::ST_RUN;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset clears the record; the store keeps its words through it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign parity_mode = s_q.parity;
    assign tx_ready = s_q.tx_go;
    assign device_instance = s_q.inst_id;
    assign comm_loss = s_q.loss;
    assign comm_loss_alarm = s_q.alarm;
    assign network_external_fault = s_q.ext_fault;
    assign bypass_contactor_open = s_q.k3_open;
    assign preset_active = s_q.preset;
    assign speed_ref_out = s_q.speed;
    assign cmd_out = s_q.cmd;
    // A restored run command may start the unit before any message.
    assign run_cmd = s_q.cmd[`BPS_CMD_RUN_FWD] | s_q.cmd[`BPS_CMD_RUN_REV];
    assign merged_inputs = s_q.merged;
    assign ready = (s_q.st == bps_pkg::ST_RUN);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // A command with zero delay, then the wait of two edges.
    sequence s_cmd_now;
        cmd_received && response_delay == 7'h00 && !s_q.dly_run;
    endsequence

    sequence s_answer;
        !tx_ready ##2 tx_ready ##1 !tx_ready;
    endsequence

    a_parity_bacnet: assert property (
        protocol_select == `BPS_PROTO_BACNET |=> parity_mode == 2'h0)
        else $error("parity not ignored under BACnet");

    a_parity_code: assert property (
        protocol_select != `BPS_PROTO_BACNET && parity_select <= 2'h2
        |=> parity_mode == $past(parity_select))
        else $error("parity mode differs from selection");

    a_zero_delay: assert property (s_cmd_now |-> s_answer)
        else $error("zero delay answer not after two edges");

    a_frame_reload: assert property (frame_ok |=> !comm_loss)
        else $error("frame did not clear loss");

    a_loss_cause: assert property (
        $rose(comm_loss) |-> $past(loss_time) != 10'h000 &&
        $past(s_q.ms_cnt) + 17'h00001 >= $past(loss_limit))
        else $error("loss raised before the loss time");

    a_loss_off: assert property (loss_time == 10'h000 |=> !comm_loss)
        else $error("loss raised with timeout disabled");

    a_contactor: assert property (
        comm_loss && loss_detect_enable &&
        loss_reaction_select == `BPS_REACT_FAULT_OPEN
        |=> bypass_contactor_open && network_external_fault)
        else $error("reaction 3 missing fault or contactor");

    a_enable_gate: assert property (
        !loss_detect_enable |=> !comm_loss_alarm &&
        !network_external_fault && !bypass_contactor_open && !preset_active)
        else $error("reaction applied while detection disabled");

    a_preset_speed: assert property (
        preset_active |-> speed_ref_out <= 16'(`BPS_SPEED_MAX))
        else $error("preset speed above limit");

    a_merge_off: assert property (
        !net_input_select |=> merged_inputs == $past(s_q.sync2))
        else $error("network inputs leaked through");

    a_no_fault_reset: assert property (
        s_q.st == bps_pkg::ST_APPLY |=> !cmd_out[`BPS_CMD_FAULT_RESET])
        else $error("fault reset bit restored");

    a_restore_none: assert property (
        s_q.st == bps_pkg::ST_APPLY && !ret_ok |=> (cmd_out == 12'h000 &&
        speed_ref_out == 16'h0000) || preset_active)
        else $error("values restored while retention not allowed");

endmodule // bps_supervisor

// [testbench/bps_net_master.sv]
/*
 * Network master model: frames, commands and word writes.
 * Assumes the bench calls its tasks from the sys_clk domain.
 */
`timescale 1ns/1ps

module bps_net_master (
    // Clock shared with the supervisor.
    input wire logic sys_clk,
    // Frame and command events.
    output logic frame_ok,
    output logic cmd_received,
    // Word writes and network inputs.
    output logic net_wr,
    output logic net_addr,
    output logic [15:0] net_wdata,
    output logic [7:0] net_inputs
);
    // Idle values at time zero.
    initial begin
        frame_ok = 1'b0;
        cmd_received = 1'b0;
        net_wr = 1'b0;
        net_addr = 1'b0;
        net_wdata = 16'h0000;
        net_inputs = 8'h00;
    end

    // One good frame, a single-cycle pulse.
    task automatic send_frame();
        @(posedge sys_clk);
        frame_ok <= 1'b1;
        @(posedge sys_clk);
        frame_ok <= 1'b0;
    endtask

    // One command that wants an answer.
    task automatic send_cmd();
        @(posedge sys_clk);
        cmd_received <= 1'b1;
        @(posedge sys_clk);
        cmd_received <= 1'b0;
    endtask

    // Data is inverted once released, so a late sample never matches.
    task automatic write_word(input logic addr, input logic [15:0] data);
        @(posedge sys_clk);
        net_wr <= 1'b1;
        net_addr <= addr;
        net_wdata <= data;
        @(posedge sys_clk);
        net_wr <= 1'b0;
        net_addr <= ~addr;
        net_wdata <= ~data;
    endtask

    // Network digital inputs as a level.
    task automatic set_net(input logic [7:0] v);
        @(posedge sys_clk);
        net_inputs <= v;
    endtask
endmodule // bps_net_master

// [testbench/tb_top.sv]
/*
 * Self-checking bench of the bypass serial supervisor.
 * Assumes the master model stands on the protocol engine side.
 */
`timescale 1ns/1ps

module tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    // Shortened millisecond keeps loss and delay counts brief.
    localparam int MS = 10;
    logic sys_clk = 1'b0, arst_n = 1'b0;
    logic [1:0] protocol_select = 2'h0, parity_select = 2'h0;
    logic [2:0] loss_reaction_select = 3'h1;
    logic [9:0] loss_time = 10'h000, cable_loss_speed = 10'h000;
    logic [6:0] response_delay = 7'h05;
    logic [15:0] instance_id_low = 16'h0001, instance_id_high = 16'h0000;
    logic loss_detect_enable = 1'b1, net_input_select = 1'b0;
    logic [1:0] command_retention_select = 2'h0;
    logic speed_ref_serial = 1'b0, run_cmd_serial = 1'b0;
    logic [7:0] physical_inputs = 8'h00, net_inputs, merged_inputs;
    logic frame_ok, cmd_received, net_wr, net_addr, tx_ready, ready;
    logic [15:0] net_wdata, speed_ref_out;
    logic [1:0] parity_mode;
    logic [21:0] device_instance;
    logic comm_loss, comm_loss_alarm, network_external_fault;
    logic bypass_contactor_open, preset_active, run_cmd;
    logic [11:0] cmd_out;
    int n_mismatch = 0;
    int tests_run = 0;
    int i;

    always #2.5 sys_clk = ~sys_clk;

    bps_supervisor #(.MS_CYCLES(MS)) uut (.*);
    bps_net_master master (.*);

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Verdict and end of run.
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // A wait that used its whole bound ends the run.
    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            $display("[ERR] wait expected done seen timeout");
            conclude();
        end
    endtask

    // Sample a little after the edge so its updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 20 && ready !== 1'b1; i++) tick(1);
        give_up(i, 20);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Every parity code, once with BACnet active and once without.
    task automatic t_parity();
        logic [1:0] e;
        for (int p = 0; p < 8; p++) begin
            @(posedge sys_clk);
            protocol_select <= (p >= 4) ? 2'h3 : 2'h0;
            parity_select <= p[1:0];
            tick(3);
            e = (p >= 4 || p[1:0] == 2'h3) ? 2'h0 : p[1:0];
            check("parity_mode", parity_mode, e);
        end
    endtask

    task automatic t_ident();
        @(posedge sys_clk);
        instance_id_low <= 16'hd687;
        instance_id_high <= 16'h0012;
        tick(3);
        check("device_instance", device_instance, 32'h12d687);
        @(posedge sys_clk);
        instance_id_high <= 16'h0040;
        tick(3);
        check("instance cap", device_instance, 32'h3fd687);
    endtask

    // Merge off, then on, with disjoint bits on each side.
    task automatic t_merge();
        master.set_net(8'h5a);
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            net_input_select <= s[0];
            physical_inputs <= 8'h81;
            tick(6);
            check("merged", merged_inputs, s ? 8'hdb : 8'h81);
        end
    endtask

    // Two milliseconds: the answer comes on its cycle, and is one pulse.
    // Then a zero delay, which answers two edges after the command.
    task automatic t_response();
        @(posedge sys_clk);
        response_delay <= 7'h02;
        master.send_cmd();
        for (i = 0; i < 18 && tx_ready !== 1'b1; i++) tick(1);
        check("tx_ready early", tx_ready, 1'b0);
        for (i = 0; i < 8 && tx_ready !== 1'b1; i++) tick(1);
        give_up(i, 8);
        check("tx_ready cycle", 18 + i, 2 * MS + 1);
        tick(1);
        check("tx_ready pulse", tx_ready, 1'b0);
        @(posedge sys_clk);
        response_delay <= 7'h00;
        master.send_cmd();
        tick(1);
        check("tx_ready zero", tx_ready, 1'b1);
        tick(1);
        check("tx_ready zero end", tx_ready, 1'b0);
    endtask

    // Frames every 702 cycles hold off a 1000-cycle limit.
    task automatic t_keepalive();
        @(posedge sys_clk);
        loss_time <= 10'h001;
        for (int k = 0; k < 3; k++) begin
            master.send_frame();
            tick(700);
        end
        check("loss kept off", comm_loss, 1'b0);
        @(posedge sys_clk);
        loss_time <= 10'h000;
        tick(1500);
        check("loss disabled", comm_loss, 1'b0);
    endtask

    // Loss after 0.1 s of silence, then the reaction of one code.
    task automatic t_loss(input logic [2:0] c, input logic en);
        logic [3:0] e;
        @(posedge sys_clk);
        loss_reaction_select <= c;
        loss_detect_enable <= en;
        cable_loss_speed <= 10'h258;
        loss_time <= 10'h001;
        master.send_frame();
        tick(990);
        check("loss early", comm_loss, 1'b0);
        for (i = 0; i < 20 && comm_loss !== 1'b1; i++) tick(1);
        give_up(i, 20);
        check("loss cycle", 990 + i, 100 * MS);
        tick(2);
        e[3] = en && (c == 3'h1 || c == 3'h4);
        e[2] = en && (c == 3'h2 || c == 3'h3);
        e[1] = en && c == 3'h3;
        e[0] = en && c == 3'h4;
        check("alarm", comm_loss_alarm, e[3]);
        check("fault", network_external_fault, e[2]);
        check("open", bypass_contactor_open, e[1]);
        check("preset", preset_active, e[0]);
        check("speed", speed_ref_out, e[0] ? 16'h0258 : 16'h0);
        master.send_frame();
        tick(3);
        check("cleared", {comm_loss, network_external_fault}, 2'h0);
    endtask

    // Words written, power cycled, restored per code and source.
    task automatic t_retain(input logic [1:0] c, input logic bac,
                            input logic src);
        logic [15:0] es;
        logic [11:0] ec;
        es = (bac && src && c[0]) ? 16'h0123 : 16'h0000;
        ec = (bac && src && c[1]) ? 12'h7ff : 12'h000;
        @(posedge sys_clk);
        protocol_select <= bac ? 2'h3 : 2'h1;
        command_retention_select <= c;
        speed_ref_serial <= src;
        run_cmd_serial <= src & c[1];
        loss_time <= 10'h000;
        master.write_word(1'b0, 16'h0123);
        master.write_word(1'b1, 16'h0fff);
        tick(3);
        check("cmd written", cmd_out, 12'hfff);
        do_reset();
        tick(2);
        check("speed restored", speed_ref_out, es);
        check("cmd restored", cmd_out, ec);
        check("run restored", run_cmd, ec[0]);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        do_reset();
        t_parity();
        t_ident();
        t_merge();
        t_response();
        t_keepalive();
        for (int c = 0; c < 5; c++) t_loss(c[2:0], 1'b1);
        t_loss(3'h3, 1'b0);
        for (int c = 0; c < 4; c++) t_retain(c[1:0], 1'b1, 1'b1);
        t_retain(2'h3, 1'b0, 1'b1);
        t_retain(2'h3, 1'b1, 1'b0);
        conclude();
    end
endmodule // tb_top
